/* cmcb_pkg.sv */
// Constants, types and register map of the cell monitor calibration and balance block.
// Assumes one 25 MHz clock and a host reaching the registers over a two-wire serial port.
// Function
// (R1) Cell 6 trim byte at 0x16, offset high nibble
// (R2) Cell 6 offset: 5-bit signed, extension on top
// (R3) Cell 6 gain: 5-bit signed, extension on top
// (R4) 0x17 holds cell 1-2 extensions, low nibble unused
// (R5) 0x18 holds cell 3-6 offset/gain extensions
// (R6) 0x1B bit2/bit1 offset tops, bit0 gain top
// (R7) Reference offset: 6-bit signed from two extensions
// (R8) Reference gain: 5-bit signed from one extension
// (R9) Sleep bit write puts device in shutdown
// (R10) Wake detector disarmed until regulator fully discharged
// (R11) Outside party wakes device by raising alert
// (R12) Each balance switch follows its own host command
// (R13) No autonomous balance duty cycling; host manages it
// (R14) Cell measurement may stay on during balancing
// (R15) Adjacent balance requests keep both switches off
// (R16) Unused extension bits read as zero
package cmcb_pkg;

    // Register offsets
    localparam logic [7:0] CMCB_POWER_CONTROL_REG_ADDR = 8'h03;
    localparam logic [7:0] CMCB_BALANCE_ADDR   = 8'h04;
    localparam logic [7:0] CMCB_TRIM_BASE_ADDR = 8'h10;
    localparam logic [7:0] CMCB_CELL6_LOW_ADDR = 8'h16;
    localparam logic [7:0] CMCB_EXT12_ADDR     = 8'h17;
    localparam logic [7:0] CMCB_EXT36_ADDR     = 8'h18;
    localparam logic [7:0] CMCB_REF_EXT_ADDR   = 8'h1B;

    // Power control field positions
    localparam int CMCB_PWR_REF_EN_BIT    = 0;
    localparam int CMCB_PWR_TB_EN_BIT     = 1;
    localparam int CMCB_PWR_CELL_AMP_BIT  = 2;
    localparam int CMCB_PWR_CUR_AMP_BIT   = 3;
    localparam int CMCB_PWR_CUR_COMP_BIT  = 4;
    localparam int CMCB_PWR_SLEEP_DIS_BIT = 6;
    localparam int CMCB_PWR_SLEEP_BIT     = 7;

    // Read masks for registers with unused bits
    localparam logic [7:0] CMCB_EXT12_MASK   = 8'hF0;
    localparam logic [7:0] CMCB_REF_EXT_MASK = 8'h07;
    localparam logic [7:0] CMCB_BALANCE_MASK = 8'h3F;

    // Reset values
    localparam logic [7:0] CMCB_POWER_CONTROL_REG_RST = 8'h00;
    localparam logic [5:0] CMCB_BALANCE_RST   = 6'h00;

    // Serial port bit counts
    localparam logic [3:0] CMCB_BITS_PER_BYTE = 4'h8;

    // Serial port states
    typedef enum logic [3:0] {
        CMCB_SER_IDLE  = 4'b0000,
        CMCB_SER_ADDR  = 4'b0001,
        CMCB_SER_ACK_A = 4'b0010,
        CMCB_SER_REG   = 4'b0011,
        CMCB_SER_WDATA = 4'b0100,
        CMCB_SER_ACK_W = 4'b0101,
        CMCB_SER_RDATA = 4'b0110,
        CMCB_SER_ACK_R = 4'b0111
    } cmcb_ser_e;

    // Power states
    typedef enum logic [1:0] {
        CMCB_PWR_ACTIVE = 2'b00,
        CMCB_PWR_DRAIN  = 2'b01,
        CMCB_PWR_ARMED  = 2'b10
    } cmcb_pwr_e;

endpackage

/* cmcb_top.sv */
// Calibration store, sleep control and cell balance control behind a two-wire serial port.
// Assumes an open-drain data line resolved outside and a host that owns the clock line.
`timescale 1ns/1ps
module cmcb_top
    import cmcb_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR   = 7'h08,
    // Factory trim image, bytes 0x10 to 0x1B, byte 0 in the low bits
    parameter logic [95:0] TRIM_IMAGE = 96'h0
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Serial port pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Power sense and wake pins
    input  wire logic        regulated_3v3_output_zero_i,
    input  wire logic        alert_i,
    // Power and analog enables
    output logic             shutdown_o,
    output logic             wake_armed_o,
    output logic [7:0]       power_control_o,
    // Balance switches
    output logic [5:0]       balance_on_o,
    // Correction factors, cell 1 in the low bits
    output logic [29:0]      cell_offset_corr_o,
    output logic [29:0]      cell_gain_corr_o,
    output logic [5:0]       ref_offset_corr_o,
    output logic [4:0]       ref_gain_corr_o
);

    // Trim byte at an offset from the trim base
    function automatic logic [7:0] trim_byte(input logic [7:0] addr);
        logic [3:0] idx;
        idx = 4'(addr - CMCB_TRIM_BASE_ADDR);
        trim_byte = TRIM_IMAGE[8*idx +: 8];
    endfunction

    // Offset correction of cell n (1..6)
    function automatic logic [4:0] cell_offset(input int n);
        logic [7:0] low;
        logic [7:0] e12;
        logic [7:0] e36;
        logic       ext;
        low = trim_byte(8'(CMCB_TRIM_BASE_ADDR + 8'(n)));
        e12 = trim_byte(CMCB_EXT12_ADDR);
        e36 = trim_byte(CMCB_EXT36_ADDR);
        if (n <= 2) begin
            ext = e12[9 - 2*n]; // [R4]
        end else begin
            ext = e36[13 - 2*n]; // [R5]
        end
        cell_offset = {ext, low[7:4]}; // [R1] [R2]
    endfunction

    // Gain correction of cell n (1..6)
    function automatic logic [4:0] cell_gain(input int n);
        logic [7:0] low;
        logic [7:0] e12;
        logic [7:0] e36;
        logic       ext;
        low = trim_byte(8'(CMCB_TRIM_BASE_ADDR + 8'(n)));
        e12 = trim_byte(CMCB_EXT12_ADDR);
        e36 = trim_byte(CMCB_EXT36_ADDR);
        if (n <= 2) begin
            ext = e12[8 - 2*n]; // [R4]
        end else begin
            ext = e36[12 - 2*n]; // [R5]
        end
        cell_gain = {ext, low[3:0]}; // [R3]
    endfunction

    // Whole correction vectors
    function automatic logic [29:0] all_offsets();
        for (int n = 1; n <= 6; n++) begin
            all_offsets[5*(n-1) +: 5] = cell_offset(n);
        end
    endfunction

    function automatic logic [29:0] all_gains();
        for (int n = 1; n <= 6; n++) begin
            all_gains[5*(n-1) +: 5] = cell_gain(n);
        end
    endfunction

    // Reference corrections
    localparam logic [7:0] REF_LOW = TRIM_IMAGE[7:0];
    localparam logic [7:0] REF_EXT = TRIM_IMAGE[95:88];
    localparam logic [5:0] REF_OFFSET = {REF_EXT[2], REF_EXT[1], REF_LOW[7:4]}; // [R6] [R7]
    localparam logic [4:0] REF_GAIN   = {REF_EXT[0], REF_LOW[3:0]};             // [R6] [R8]
    localparam logic [29:0] CELL_OFFSETS = all_offsets();
    localparam logic [29:0] CELL_GAINS   = all_gains();

    // Balance gating: a request beside another request is dropped
    function automatic logic [5:0] gate_balance(input logic [5:0] req);
        logic [5:0] lo;
        logic [5:0] hi;
        lo = {req[4:0], 1'b0};
        hi = {1'b0, req[5:1]};
        gate_balance = req & ~lo & ~hi; // [R12] [R15]
    endfunction

    // Register read decode
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] pwr,
                                            input logic [5:0] bal);
        read_reg = 8'h00;
        if (addr == CMCB_POWER_CONTROL_REG_ADDR) begin
            read_reg = pwr;
        end else if (addr == CMCB_BALANCE_ADDR) begin
            read_reg = {2'b00, bal};
        end else if (addr == CMCB_EXT12_ADDR) begin
            read_reg = trim_byte(addr) & CMCB_EXT12_MASK; // [R16]
        end else if (addr == CMCB_REF_EXT_ADDR) begin
            read_reg = trim_byte(addr) & CMCB_REF_EXT_MASK; // [R16]
        end else if (addr >= CMCB_TRIM_BASE_ADDR && addr <= CMCB_EXT36_ADDR) begin
            read_reg = trim_byte(addr); // [R1] [R5]
        end
    endfunction

    // All state of the block
    typedef struct packed {
        logic [2:0]  scl_sync;
        logic [2:0]  sda_sync;
        logic [1:0]  regulated_3v3_output_sync;
        logic [1:0]  alert_sync;
        cmcb_ser_e   ser;
        logic [3:0]  cnt;
        logic [7:0]  shift;
        logic [7:0]  tx;
        logic        rd;
        logic        acked;
        logic [7:0]  ptr;
        logic        sda_oe;
        cmcb_pwr_e   pwr;
        logic        shut;
        logic        armed;
        logic [7:0]  power_control_reg;
        logic [5:0]  bal_req;
        logic [5:0]  bal_on;
        logic [29:0] cell_off;
        logic [29:0] cell_gain;
        logic [5:0]  ref_off;
        logic [4:0]  ref_gain;
    } cmcb_state_s;

    localparam cmcb_state_s STATE_RST = '{
        scl_sync: 3'b111, sda_sync: 3'b111, regulated_3v3_output_sync: 2'b00, alert_sync: 2'b00,
        ser: CMCB_SER_IDLE, cnt: 4'h0, shift: 8'h00, tx: 8'h00, rd: 1'b0,
        acked: 1'b0, ptr: 8'h00, sda_oe: 1'b0, pwr: CMCB_PWR_ACTIVE,
        shut: 1'b0, armed: 1'b0,
        power_control_reg: CMCB_POWER_CONTROL_REG_RST, bal_req: CMCB_BALANCE_RST, bal_on: 6'h00,
        cell_off: CELL_OFFSETS, cell_gain: CELL_GAINS, ref_off: REF_OFFSET,
        ref_gain: REF_GAIN
    };

    cmcb_state_s state_reg;
    cmcb_state_s state_next;

    // Next state
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] rbyte;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c  = 1'b0;
        stop_c   = 1'b0;
        rbyte    = 8'h00;
        state_next = state_reg;

        // Pin synchronisers, third stage only for edge detection
        state_next.scl_sync   = {state_reg.scl_sync[1:0], scl_i};
        state_next.sda_sync   = {state_reg.sda_sync[1:0], sda_i};
        state_next.regulated_3v3_output_sync  = {state_reg.regulated_3v3_output_sync[0], regulated_3v3_output_zero_i};
        state_next.alert_sync = {state_reg.alert_sync[0], alert_i};
        scl_rise = state_reg.scl_sync[1] & ~state_reg.scl_sync[2];
        scl_fall = ~state_reg.scl_sync[1] & state_reg.scl_sync[2];
        start_c  = state_reg.scl_sync[1] & state_reg.scl_sync[2] &
                   state_reg.sda_sync[2] & ~state_reg.sda_sync[1];
        stop_c   = state_reg.scl_sync[1] & state_reg.scl_sync[2] &
                   ~state_reg.sda_sync[2] & state_reg.sda_sync[1];
        rbyte    = read_reg(state_reg.ptr, state_reg.power_control_reg, state_reg.bal_req);

        // Serial port engine
        if (start_c) begin
            state_next.ser    = CMCB_SER_ADDR;
            state_next.cnt    = 4'h0;
            state_next.sda_oe = 1'b0;
        end else if (stop_c) begin
            state_next.ser    = CMCB_SER_IDLE;
            state_next.sda_oe = 1'b0;
        end else begin
            unique case (state_reg.ser)
                CMCB_SER_IDLE: begin
                    state_next.sda_oe = 1'b0;
                end
                CMCB_SER_ADDR, CMCB_SER_REG, CMCB_SER_WDATA: begin
                    if (scl_rise) begin
                        state_next.shift = {state_reg.shift[6:0], state_reg.sda_sync[1]};
                        state_next.cnt   = 4'(state_reg.cnt + 4'h1);
                    end else if (scl_fall && state_reg.cnt == CMCB_BITS_PER_BYTE) begin
                        state_next.cnt    = 4'h0;
                        state_next.sda_oe = 1'b1;
                        if (state_reg.ser == CMCB_SER_ADDR) begin
                            state_next.rd  = state_reg.shift[0];
                            state_next.ser = CMCB_SER_ACK_A;
                            if (state_reg.shift[7:1] != DEV_ADDR) begin
                                state_next.ser    = CMCB_SER_IDLE;
                                state_next.sda_oe = 1'b0;
                            end
                        end else if (state_reg.ser == CMCB_SER_REG) begin
                            state_next.ptr = state_reg.shift;
                            state_next.ser = CMCB_SER_ACK_W;
                        end else begin
                            // Only power control and balance accept writes
                            if (state_reg.ptr == CMCB_POWER_CONTROL_REG_ADDR) begin
                                state_next.power_control_reg = state_reg.shift; // [R9]
                            end else if (state_reg.ptr == CMCB_BALANCE_ADDR) begin
                                state_next.bal_req = state_reg.shift[5:0]; // [R12]
                            end
                            state_next.ptr = 8'(state_reg.ptr + 8'h01);
                            state_next.ser = CMCB_SER_ACK_W;
                        end
                    end
                end
                CMCB_SER_ACK_A: begin
                    if (scl_fall) begin
                        state_next.cnt = 4'h0;
                        if (state_reg.rd) begin
                            state_next.tx     = rbyte;
                            state_next.sda_oe = ~rbyte[7];
                            state_next.ser    = CMCB_SER_RDATA;
                        end else begin
                            state_next.sda_oe = 1'b0;
                            state_next.ser    = CMCB_SER_REG;
                        end
                    end
                end
                CMCB_SER_ACK_W: begin
                    if (scl_fall) begin
                        state_next.sda_oe = 1'b0;
                        state_next.ser    = CMCB_SER_WDATA;
                    end
                end
                CMCB_SER_RDATA: begin
                    if (scl_rise) begin
                        state_next.cnt = 4'(state_reg.cnt + 4'h1);
                    end else if (scl_fall) begin
                        if (state_reg.cnt == CMCB_BITS_PER_BYTE) begin
                            state_next.sda_oe = 1'b0;
                            state_next.ptr    = 8'(state_reg.ptr + 8'h01);
                            state_next.ser    = CMCB_SER_ACK_R;
                        end else begin
                            state_next.tx     = {state_reg.tx[6:0], 1'b0};
                            state_next.sda_oe = ~state_reg.tx[6];
                        end
                    end
                end
                CMCB_SER_ACK_R: begin
                    if (scl_rise) begin
                        state_next.acked = ~state_reg.sda_sync[1];
                    end else if (scl_fall) begin
                        state_next.cnt = 4'h0;
                        if (state_reg.acked) begin
                            state_next.tx     = rbyte;
                            state_next.sda_oe = ~rbyte[7];
                            state_next.ser    = CMCB_SER_RDATA;
                        end else begin
                            state_next.ser = CMCB_SER_IDLE;
                        end
                    end
                end
            endcase
        end

        // Sleep entry, discharge wait and wake
        unique case (state_reg.pwr)
            CMCB_PWR_ACTIVE: begin
                if (state_reg.power_control_reg[CMCB_PWR_SLEEP_BIT] &&
                    !state_reg.power_control_reg[CMCB_PWR_SLEEP_DIS_BIT]) begin
                    state_next.pwr = CMCB_PWR_DRAIN; // [R9]
                end
            end
            CMCB_PWR_DRAIN: begin
                if (state_reg.regulated_3v3_output_sync[1]) begin
                    state_next.pwr = CMCB_PWR_ARMED; // [R10]
                end
            end
            CMCB_PWR_ARMED: begin
                if (state_reg.alert_sync[1]) begin
                    state_next.pwr = CMCB_PWR_ACTIVE; // [R11]
                    state_next.power_control_reg = CMCB_POWER_CONTROL_REG_RST;
                end
            end
            default: begin
                state_next.pwr = CMCB_PWR_ACTIVE;
            end
        endcase

        // Switches follow host commands only; no own duty cycling
        if (state_next.pwr != CMCB_PWR_ACTIVE) begin
            state_next.bal_on = 6'h00;
        end else begin
            state_next.bal_on = gate_balance(state_next.bal_req); // [R13] [R15]
        end

        // Power status flops for the pins
        state_next.shut  = (state_next.pwr != CMCB_PWR_ACTIVE);
        state_next.armed = (state_next.pwr == CMCB_PWR_ARMED);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs from state flops, sda_o tied low
    assign sda_o              = 1'b0;
    assign sda_oe_o           = state_reg.sda_oe;
    assign shutdown_o         = state_reg.shut;
    assign wake_armed_o       = state_reg.armed;
    assign power_control_o    = state_reg.power_control_reg; // [R14] cell amp independent of balance
    assign balance_on_o       = state_reg.bal_on;
    assign cell_offset_corr_o = state_reg.cell_off;
    assign cell_gain_corr_o   = state_reg.cell_gain;
    assign ref_offset_corr_o  = state_reg.ref_off;
    assign ref_gain_corr_o    = state_reg.ref_gain;

endmodule // cmcb_top

/* cmcb_assertions.sv */
// Concurrent checks on the ports of the calibration, sleep and balance block.
// Assumes one clock domain and wake inputs held as levels by the bench.
`timescale 1ns/1ps
module cmcb_chk (
    // Clock, reset and serial clock
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        scl_i,
    // Power pins and state
    input wire logic        regulated_3v3_output_zero_i,
    input wire logic        alert_i,
    input wire logic        shutdown_o,
    input wire logic        wake_armed_o,
    input wire logic [7:0]  power_control_o,
    // Balance and trim outputs
    input wire logic [5:0]  balance_on_o,
    input wire logic [29:0] cell_offset_corr_o,
    input wire logic [29:0] cell_gain_corr_o,
    input wire logic [5:0]  ref_offset_corr_o,
    input wire logic [4:0]  ref_gain_corr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       scl_q;
    logic [3:0] gap;
    // Cycles since the last serial clock fall, saturating
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q <= 1'b1;
            gap   <= 4'hF;
        end else begin
            scl_q <= scl_i;
            gap   <= (scl_q && !scl_i) ? 4'h0 : ((gap == 4'hF) ? gap : gap + 4'h1);
        end
    end
    // Steps of sleep entry and wake
    sequence s_sleep_cmd; $rose(power_control_o[7]) && !power_control_o[6]; endsequence
    sequence s_wake_req; wake_armed_o && alert_i; endsequence
    property p_no_adjacent; (balance_on_o & (balance_on_o >> 1)) == 6'h00; endproperty
    a_no_adjacent: assert property (p_no_adjacent) else $error("adjacent switches on");
    property p_sleep_entry; s_sleep_cmd |-> ##[0:2] shutdown_o; endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no shutdown");
    property p_bal_off; shutdown_o && $past(shutdown_o) |-> balance_on_o == 6'h00; endproperty
    a_bal_off: assert property (p_bal_off) else $error("balance on in shutdown");
    property p_arm_drain; $rose(wake_armed_o) |-> $past(regulated_3v3_output_zero_i, 2); endproperty
    a_arm_drain: assert property (p_arm_drain) else $error("armed before drain");
    property p_armed_asleep; wake_armed_o |-> shutdown_o; endproperty
    a_armed_asleep: assert property (p_armed_asleep) else $error("armed while awake");
    property p_drain_holds; shutdown_o && !wake_armed_o |=> shutdown_o; endproperty
    a_drain_holds: assert property (p_drain_holds) else $error("woke while unarmed");
    property p_wake; s_wake_req |-> ##[1:6] !shutdown_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake on alert");
    property p_wake_clr; $fell(shutdown_o) |-> ##[0:1] power_control_o == 8'h00; endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("power control kept");
    property p_no_cycling;
        $changed(balance_on_o) |-> shutdown_o || $past(shutdown_o) || $past(shutdown_o, 2)
            || gap < 4'hA;
    endproperty
    a_no_cycling: assert property (p_no_cycling) else $error("balance moved alone");
    property p_trim_static;
        $stable({cell_offset_corr_o, cell_gain_corr_o, ref_offset_corr_o, ref_gain_corr_o});
    endproperty
    a_trim_static: assert property (p_trim_static) else $error("trim changed");
endmodule // cmcb_chk
bind cmcb_top cmcb_chk u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .regulated_3v3_output_zero_i(regulated_3v3_output_zero_i),
    .alert_i(alert_i), .shutdown_o(shutdown_o), .wake_armed_o(wake_armed_o),
    .power_control_o(power_control_o), .balance_on_o(balance_on_o),
    .cell_offset_corr_o(cell_offset_corr_o), .cell_gain_corr_o(cell_gain_corr_o),
    .ref_offset_corr_o(ref_offset_corr_o), .ref_gain_corr_o(ref_gain_corr_o));

/* cmcb_host.sv */
// Host controller model: master of the two-wire serial port.
// Assumes a pulled-up data wire resolved by the bench from all pull-downs.
`timescale 1ns/1ps
module cmcb_host #(
    parameter logic [6:0] DEV_ADDR = 7'h08
) (
    // Clock and wire level
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Serial clock and data pull-down
    output logic      scl_o,
    output logic      pull_o
);
    logic [7:0] rd_data;
    logic       addr_nak;
    // Idle bus at time zero
    initial begin
        scl_o    = 1'b1;
        pull_o   = 1'b0;
        rd_data  = 8'h00;
        addr_nak = 1'b0;
    end
    // Changes land just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One bit: phases of eight clocks, sampled late in the high phase
    task automatic bitx(input logic b, output logic r);
        pull_o = !b;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        r = sda_i;
        scl_o = 1'b0;
        tick(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], b);
            q[i] = b;
        end
        bitx(last, ack);
    endtask
    // Start and repeated start
    task automatic start();
        pull_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        pull_o = 1'b1;
        tick(8);
        scl_o = 1'b0;
        tick(4);
    endtask
    task automatic stop();
        pull_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        pull_o = 1'b0;
        tick(8);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       k;
        start();
        xfer({dev, 1'b0}, 1'b1, q, addr_nak);
        if (!addr_nak) begin
            xfer(a, 1'b1, q, k);
            xfer(d, 1'b1, q, k);
        end
        stop();
    endtask
    // Pointer write, repeated start, one byte ended by a not-acknowledge
    task automatic read_reg(input logic [7:0] a);
        logic [7:0] q;
        logic       k;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q, k);
        xfer(a, 1'b1, q, k);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, q, k);
        xfer(8'hFF, 1'b1, rd_data, k);
        stop();
    endtask
endmodule // cmcb_host

/* cmcb_tb.sv */
// Self-checking bench for the calibration, sleep and balance block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
module testbench;
    localparam logic [6:0]  DEV  = 7'h08;
    localparam logic [95:0] TRIM = 96'hFD5A_C3A5_FF3C_96E1_7B2D_C458;
    logic        clk, rst_n, regulated_3v3_output_zero, alert, scl, pull, sda, sda_o, sda_oe, shutdown, armed;
    logic        look;
    logic [7:0]  pwr_ctl, m;
    logic [5:0]  bal, ref_off, r;
    logic [29:0] c_off, c_gain;
    logic [4:0]  ref_gain;
    logic [31:0] got, e, e_q[$];
    logic [3:0]  s, sel_q[$];
    int          n_errors, checks_done;
    // Open-drain data wire with pull-up
    assign sda = !((sda_oe && !sda_o) || pull);
    cmcb_top #(.DEV_ADDR(DEV), .TRIM_IMAGE(TRIM)) DUT (
        .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .regulated_3v3_output_zero_i(regulated_3v3_output_zero), .alert_i(alert), .shutdown_o(shutdown),
        .wake_armed_o(armed), .power_control_o(pwr_ctl), .balance_on_o(bal),
        .cell_offset_corr_o(c_off), .cell_gain_corr_o(c_gain), .ref_offset_corr_o(ref_off),
        .ref_gain_corr_o(ref_gain));
    cmcb_host #(.DEV_ADDR(DEV)) host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Notes an expectation and presents it for one cycle
    task automatic want(input logic [3:0] sel, input logic [31:0] v);
        sel_q.push_back(sel);
        e_q.push_back(v);
        look = 1'b1;
        cyc(1);
        look = 1'b0;
        cyc(1);
    endtask
    // Corrections built from the trim image: 0 offsets, 1 gains, 2 reference
    function automatic logic [31:0] trim_exp(input int w);
        logic [29:0] t;
        t = 30'h0;
        for (int n = 1; n <= 6; n++) begin
            t[5*(n-1) +: 5] = (w == 0) ? {TRIM[(n <= 2) ? 65-2*n : 77-2*n], TRIM[8*n+4 +: 4]}
                                       : {TRIM[(n <= 2) ? 64-2*n : 76-2*n], TRIM[8*n +: 4]};
        end
        return (w == 2) ? {21'h0, TRIM[90], TRIM[89], TRIM[7:4], TRIM[88], TRIM[3:0]}
                        : {2'h0, t};
    endfunction
    // Takes the oldest note when a result is presented
    always @(posedge clk) begin
        if (look) begin
            s = sel_q.pop_front();
            e = e_q.pop_front();
            case (s)
                4'h0: got = {24'h0, host.rd_data};
                4'h1: got = {26'h0, bal};
                4'h2: got = {31'h0, shutdown};
                4'h3: got = {31'h0, armed};
                4'h4: got = {24'h0, pwr_ctl};
                4'h5: got = {2'h0, c_off};
                4'h6: got = {2'h0, c_gain};
                4'h7: got = {21'h0, ref_off, ref_gain};
                default: got = {31'h0, host.addr_nak};
            endcase
            checks_done++;
            if (got !== e) begin
                n_errors++;
                $display("unexpected at %0t: item %0d is %h, expected %h", $time, s, got, e);
            end
        end
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        $display("unexpected at %0t: run hung", $time);
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        regulated_3v3_output_zero = 1'b0;
        alert = 1'b0;
        look = 1'b0;
        n_errors = 0;
        checks_done = 0;
        void'($urandom(63474));
        cyc(3);
        rst_n = 1'b1;
        cyc(4);
        want(4'h5, trim_exp(0));
        want(4'h6, trim_exp(1));
        want(4'h7, trim_exp(2));
        for (int a = 16; a <= 28; a++) begin
            host.read_reg(8'(a));
            m = (a == 23) ? 8'hF0 : (a == 27) ? 8'h07 : (a < 25) ? 8'hFF : 8'h00;
            want(4'h0, {24'h0, (a == 28) ? 8'h00 : TRIM[8*(a-16) +: 8] & m});
        end
        host.write_reg(DEV, 8'h16, 8'($urandom));
        host.read_reg(8'h16);
        want(4'h0, {24'h0, TRIM[55:48]});
        $display("test trim done");
        host.write_reg(DEV, 8'h03, 8'h04);
        for (int i = 0; i < 14; i++) begin
            r = (i < 5) ? 6'(6'h3 << i) : ((i == 5) ? 6'h3F : 6'($urandom));
            host.write_reg(DEV, 8'h04, {2'h0, r});
            host.read_reg(8'h04);
            want(4'h0, {26'h0, r});
            want(4'h1, {26'h0, r & ~(r << 1) & ~(r >> 1)});
        end
        host.write_reg(DEV, 8'h04, 8'h15);
        cyc(300);
        want(4'h1, 32'h15);
        want(4'h4, 32'h04);
        $display("test balance done");
        host.write_reg(DEV, 8'h03, 8'hC0);
        want(4'h2, 32'h0);
        host.write_reg(DEV, 8'h03, 8'h00);
        host.write_reg(DEV, 8'h03, 8'h80);
        want(4'h2, 32'h1);
        want(4'h1, 32'h0);
        alert = 1'b1;
        cyc(10);
        alert = 1'b0;
        want(4'h2, 32'h1);
        want(4'h3, 32'h0);
        regulated_3v3_output_zero = 1'b1;
        cyc(6);
        want(4'h3, 32'h1);
        alert = 1'b1;
        cyc(8);
        want(4'h2, 32'h0);
        want(4'h4, 32'h0);
        alert = 1'b0;
        regulated_3v3_output_zero = 1'b0;
        $display("test sleep done");
        host.write_reg(DEV, 8'h04, 8'h21);
        host.write_reg(7'(DEV ^ 7'h01), 8'h04, 8'h3F);
        want(4'h8, 32'h1);
        want(4'h1, 32'h21);
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        cyc(4);
        want(4'h1, 32'h0);
        want(4'h5, trim_exp(0));
        $display("test address and reset done");
        report_and_stop();
    end
endmodule // testbench
